// ---- dv/mpurc_checker_props.sv ----
// Purpose: Port assertions for the region checker
// Assumes: One clock, async active-low reset
// Notes: Bound to every checker instance
`timescale 1ns/1ps
module mpurc_checker_props (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic prot_enable_wr,
    input wire logic prot_enable_in,
    input wire logic ctl_wr,
    input wire mpurc_pkg::mpurc_region_type ctl_in,
    input wire logic acc_cmd_wr,
    input wire mpurc_pkg::mpurc_access_type access,
    input wire logic prot_enabled,
    input wire mpurc_pkg::mpurc_region_type ctl_out,
    input wire mpurc_pkg::mpurc_verdict_type verdict
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    en_hold_a: assert property (!$past(clk_en && prot_enable_wr) |->
        $stable(prot_enabled)) else $error("enable moved");
    en_load_a: assert property (clk_en && prot_enable_wr |=>
        prot_enabled == $past(prot_enable_in)) else $error("enable load");
    off_quiet_a: assert property (clk_en && !prot_enabled &&
        !prot_enable_wr |=> !verdict.fault) else $error("fault while off");
    top_miss_a: assert property (clk_en && prot_enabled &&
        !prot_enable_wr && access.valid && access.addr[31] |=>
        verdict.fault && !verdict.hit) else $error("top half matched");
    miss_fault_a: assert property ($past(clk_en && access.valid &&
        prot_enabled && !prot_enable_wr) && !verdict.hit |-> verdict.fault)
        else $error("miss passed");
    fault_cause_a: assert property ($past(clk_en) && verdict.fault |->
        $past(access.valid && prot_enabled)) else $error("stray fault");
    ctl_load_a: assert property (clk_en && ctl_wr && !acc_cmd_wr |=>
        ctl_out == $past(ctl_in)) else $error("ctl load");
    ctl_hold_a: assert property (!(clk_en && (ctl_wr || acc_cmd_wr)) |=>
        $stable(ctl_out)) else $error("ctl moved");
endmodule : mpurc_checker_props

bind mpurc_checker mpurc_checker_props u_props (.*);

// ---- dv/mpurc_checker_tb_top.sv ----
// Purpose: Self-checking bench for the region checker
// Assumes: Mask variant, 64-byte minimum region
// Notes: Verdict bits are fault, hit, cache
`timescale 1ns/1ps
module mpurc_checker_tb_top;
    logic clk, nrst, clk_en, prot_enable_wr, prot_enable_in, ctl_wr;
    logic acc_cmd_wr, cmd_rd, cmd_wr, prot_enabled;
    logic [mpurc_pkg::IDX_W-1:0] cmd_index;
    mpurc_pkg::mpurc_region_type ctl_in, ctl_out;
    mpurc_pkg::mpurc_access_type access;
    mpurc_pkg::mpurc_verdict_type verdict;
    int fail_count = 0;
    int checked = 0;
    mpurc_checker u_dut (.*);
    mpurc_core_model u_core (.clk(clk), .access(access));
    task automatic chk(input string n, input logic [63:0] e, g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic put(input logic [24:0] s, m, input logic d,
                       input logic [2:0] p, k, input logic rd);
        @(posedge clk);
        ctl_wr <= 1'b1;
        ctl_in <= '{s, m, d, 1'b0, p};
        @(posedge clk);
        ctl_wr <= 1'b0;
        acc_cmd_wr <= 1'b1;
        cmd_rd <= rd;
        cmd_wr <= !rd;
        cmd_index <= k;
        @(posedge clk);
        acc_cmd_wr <= 1'b0;
    endtask : put
    task automatic acc(input logic f, w, input logic [31:0] a,
                       input logic [2:0] v);
        u_core.issue('{1'b1, f, w, 1'b1, a});
        #1 chk("verdict", {61'h0, v}, {61'h0, verdict});
    endtask : acc
    task automatic t_reset;
        chk("enabled", 64'h0, {63'h0, prot_enabled});
        acc(1'b0, 1'b0, 32'h0, 3'h0);
    endtask : t_reset
    task automatic t_table;
        put(25'h840, 25'h1ffffff, 1'b1, 3'h0, 3'h0, 1'b0);
        put(25'h800, 25'h1ffff80, 1'b1, 3'h6, 3'h1, 1'b0);
        put(25'h400, 25'h1ffff00, 1'b0, 3'h2, 3'h2, 1'b0);
        put(25'h1, 25'h0, 1'b1, 3'h6, 3'h3, 1'b0);
        put(25'h5, 25'h5, 1'b0, 3'h1, 3'h1, 1'b1);
        #1 chk("ctl_out", {9'h0, 25'h800, 25'h1ffff80, 5'h16}, ctl_out);
    endtask : t_table
    task automatic t_check;
        @(posedge clk);
        prot_enable_wr <= 1'b1;
        prot_enable_in <= 1'b1;
        @(posedge clk);
        prot_enable_wr <= 1'b0;
        #1 chk("enabled", 64'h1, {63'h0, prot_enabled});
        acc(1'b0, 1'b1, 32'h21000, 3'h6);
        acc(1'b0, 1'b1, 32'h21040, 3'h2);
        acc(1'b0, 1'b0, 32'h10000, 3'h4);
        acc(1'b1, 1'b0, 32'h10000, 3'h2);
        acc(1'b1, 1'b0, 32'h0, 3'h6);
        acc(1'b0, 1'b0, 32'h40, 3'h4);
        acc(1'b0, 1'b0, 32'h80000000, 3'h4);
    endtask : t_check
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100us;
        fail_count++;
        tally_and_finish();
    end
    initial begin
        {nrst, prot_enable_wr, prot_enable_in, ctl_wr, acc_cmd_wr} = '0;
        {cmd_rd, cmd_wr, cmd_index, ctl_in} = '0;
        clk_en = 1'b1;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_table();
        t_check();
        tally_and_finish();
    end
endmodule : mpurc_checker_tb_top

// ---- dv/mpurc_core_model.sv ----
// Purpose: Pipeline model issuing one access at a time
// Assumes: Access taken at the edge after issue
// Notes: Released address is inverted, never left stale
`timescale 1ns/1ps
module mpurc_core_model (
    input wire logic clk,
    output mpurc_pkg::mpurc_access_type access
);
    initial access = '0;
    task automatic issue(input mpurc_pkg::mpurc_access_type a);
        @(posedge clk);
        access <= a;
        @(posedge clk);
        access <= {4'h0, ~a.addr};
    endtask : issue
endmodule : mpurc_core_model

// ---- rtl/mpurc_checker.sv ----
// Purpose: Region table, descriptor load/store and access checking
// Assumes: One access checked per enabled clock, verdict registered
// Notes: Variant chosen by parameter USE_LIMIT
`timescale 1ns/1ps
// Functional notes
// (RQ1) Read flag copies selected region to control
// (RQ2) Write flag stores control into selected region
// (RQ3) Software never sets both flags together
// (RQ4) Software disables every unused region
// (RQ5) Size variant: nonzero start, full size disables
// (RQ6) Bound variant: nonzero start, zero bound disables
// (RQ7) Disabled only when start field nonzero
// (RQ8) Software uses power-of-two sizes, minimum or more
// (RQ9) Software aligns start to region size
// (RQ10) Overlapping regions are permitted
// (RQ11) Highest-priority matching region alone governs
// (RQ12) Protection off after reset
// (RQ13) Software disables protection while reconfiguring
// (RQ14) Unmatched data access faults when enabled
// (RQ15) Fetch without execute permission faults
// (RQ16) Address space is 2 GB
// (RQ17) Lower index means higher priority
// (RQ18) Type flag picks instruction or data set
// (RQ19) Bound holds next address over minimum size
// (RQ20) Match is start <= addr < end
// (RQ21) Fetches use instruction regions, data uses data
module mpurc_checker #(
    parameter bit USE_LIMIT = 1'b0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic prot_enable_wr,
    input wire logic prot_enable_in,
    input wire logic ctl_wr,
    input wire mpurc_pkg::mpurc_region_type ctl_in,
    input wire logic acc_cmd_wr,
    input wire logic cmd_rd,
    input wire logic cmd_wr,
    input wire logic [mpurc_pkg::IDX_W-1:0] cmd_index,
    input wire mpurc_pkg::mpurc_access_type access,
    output logic prot_enabled,
    output mpurc_pkg::mpurc_region_type ctl_out,
    output mpurc_pkg::mpurc_verdict_type verdict
);
    localparam int unsigned N = mpurc_pkg::NUM_REGIONS;
    localparam int unsigned W = mpurc_pkg::FLD_W;
    localparam logic [W:0] FULL_UNITS =
        (W+1)'(64'd1 << (mpurc_pkg::SPACE_SHIFT - mpurc_pkg::MIN_SHIFT));

    mpurc_pkg::mpurc_state_type state_ff;
    mpurc_pkg::mpurc_state_type nxt_state;
    logic [N-1:0] match;
    logic [W-1:0] addr_unit;

    assign addr_unit = access.addr[mpurc_pkg::MIN_SHIFT +: W];

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_region
            mpurc_pkg::mpurc_region_type r;
            logic [W:0] end_unit;
            logic [W:0] size_units;
            logic off;
            assign r = state_ff.tbl[g];
            // Size from mask: inverted mask plus one, in minimum units
            assign size_units = {1'b0, ~r.bound} + (W+1)'(1);
            assign end_unit = USE_LIMIT ? {1'b0, r.bound} // RQ19
                : ({1'b0, r.start} + size_units);
            assign off = (r.start != '0) && (USE_LIMIT // RQ7
                ? (r.bound == '0) // RQ6
                : (size_units == FULL_UNITS)); // RQ5 RQ16
            assign match[g] = !off && (r.data == !access.fetch) // RQ18 RQ21
                && ({1'b0, addr_unit} >= {1'b0, r.start}) // RQ20
                && ({1'b0, addr_unit} < end_unit) // RQ20
                && (access.addr[mpurc_pkg::ADDR_W-1] == 1'b0); // RQ16
        end
    endgenerate

    function automatic logic allowed(input mpurc_pkg::mpurc_region_type r,
                                     input mpurc_pkg::mpurc_access_type a);
        logic ok;
        ok = 1'b0;
        if (a.fetch) begin
            ok = (r.perm == mpurc_pkg::IPERM_ALL_X)
                || (!a.user && r.perm == mpurc_pkg::IPERM_SUP_X); // RQ15
        end else if (a.write) begin
            ok = (r.perm == mpurc_pkg::DPERM_ALL_RW)
                || (!a.user && (r.perm == mpurc_pkg::DPERM_SUP_RW
                || r.perm == mpurc_pkg::DPERM_SUP_RW_USR_R));
        end else begin
            ok = (r.perm == mpurc_pkg::DPERM_ALL_R)
                || (r.perm == mpurc_pkg::DPERM_SUP_RW_USR_R)
                || (r.perm == mpurc_pkg::DPERM_ALL_RW)
                || (!a.user && (r.perm == mpurc_pkg::DPERM_SUP_R
                || r.perm == mpurc_pkg::DPERM_SUP_RW));
        end
        return ok;
    endfunction : allowed

    always_comb begin
        mpurc_pkg::mpurc_region_type win;
        logic found;
        win = '0;
        found = 1'b0;
        nxt_state = state_ff;
        if (prot_enable_wr) begin
            nxt_state.enable = prot_enable_in;
        end
        if (ctl_wr) begin
            nxt_state.ctl = ctl_in;
        end
        if (acc_cmd_wr && cmd_rd && !cmd_wr) begin // RQ3
            nxt_state.ctl = state_ff.tbl[cmd_index]; // RQ1
        end else if (acc_cmd_wr && cmd_wr && !cmd_rd) begin
            nxt_state.tbl[cmd_index] = state_ff.ctl; // RQ2
        end
        // Descending scan leaves the lowest index as winner
        for (int i = N - 1; i >= 0; i--) begin
            if (match[i]) begin // RQ17
                win = state_ff.tbl[i];
                found = 1'b1;
            end
        end
        nxt_state.verdict.hit = access.valid && found;
        nxt_state.verdict.cache = access.valid && found // RQ11
            && win.data && win.cache;
        nxt_state.verdict.fault = access.valid && state_ff.enable // RQ12
            && (!found || !allowed(win, access)); // RQ14 RQ15 RQ11
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= '0; // RQ12
        end else if (clk_en) begin
            state_ff <= nxt_state;
        end
    end

    assign prot_enabled = state_ff.enable;
    assign ctl_out = state_ff.ctl;
    assign verdict = state_ff.verdict;
endmodule : mpurc_checker

// ---- rtl/mpurc_pkg.sv ----
// Purpose: Shared constants and carriers for the region checker
// Assumes: 32-bit addresses, 64-byte minimum region, 2 GB space
// Notes: Both size-pattern and upper-bound variants are supported
package mpurc_pkg;
    localparam int unsigned NUM_REGIONS = 8;
    localparam int unsigned IDX_W = 3;
    localparam int unsigned MIN_SHIFT = 6;
    localparam int unsigned FLD_W = 25;
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned SPACE_SHIFT = 31;
    localparam logic [FLD_W-1:0] FLD_RESET = 25'h0000000;
    localparam logic [2:0] PERM_RESET = 3'h0;
    localparam logic [2:0] IPERM_SUP_X = 3'h1;
    localparam logic [2:0] IPERM_ALL_X = 3'h2;
    localparam logic [2:0] DPERM_SUP_R = 3'h1;
    localparam logic [2:0] DPERM_ALL_R = 3'h2;
    localparam logic [2:0] DPERM_SUP_RW = 3'h4;
    localparam logic [2:0] DPERM_SUP_RW_USR_R = 3'h5;
    localparam logic [2:0] DPERM_ALL_RW = 3'h6;

    typedef struct packed {
        logic [FLD_W-1:0] start;
        logic [FLD_W-1:0] bound;
        logic data;
        logic cache;
        logic [2:0] perm;
    } mpurc_region_type;

    typedef struct packed {
        logic valid;
        logic fetch;
        logic write;
        logic user;
        logic [ADDR_W-1:0] addr;
    } mpurc_access_type;

    typedef struct packed {
        logic fault;
        logic hit;
        logic cache;
    } mpurc_verdict_type;

    typedef struct packed {
        mpurc_region_type [NUM_REGIONS-1:0] tbl;
        mpurc_region_type ctl;
        logic enable;
        mpurc_verdict_type verdict;
    } mpurc_state_type;
endpackage : mpurc_pkg
